// *** design/coag_addr_gen.sv ***
// Functional notes
// - Inherent instructions are one byte; nothing is fetched after the opcode.
// - Immediate mode fetches one byte after opcode, used as operand value.
// - Short direct takes one address byte, operand within 00 to FF.
// - Long direct fetches a two-byte address word reaching all 64 Kbytes.
// - Indexed address is unsigned sum of index register X or Y and offset.
// - No-offset indexed fetches nothing; index alone gives address 00 to FF.
// - Short indexed: one offset byte, sum kept unwrapped, 00 to 1FE.
// - Long indexed: two-byte offset word plus index covers 64 Kbytes.
// - Indirect: one pointer-location byte; pointer is byte (short) or word (long).
// - Short indirect uses fetched byte pointer directly, operand 00 to FF.
// - Indirect indexed address is index plus pointer read from memory.
// - Short indirect indexed: byte pointer plus index gives 00 to 1FE.
// - Short direct and indirect forms reach page zero only; long forms reach 64 Kbytes.
// - Read-modify-write instructions are accepted only with short forms.
// - Long forms take more bytes and cycles than short forms.
// - Seventeen addressing modes in seven groups are supported.
// - Set-mask inherent instruction raises interrupt mask to level 3.
// - Clear-mask inherent instruction lowers interrupt mask to level 0.
// - Halt stops oscillator; wait idles core until an interrupt arrives.
// - Relative modes add 8-bit signed offset to program counter.
`timescale 1ns/1ps
module coag_addr_gen #(
    parameter int ADDR_W = coag_pkg::ADDR_W,
    parameter int BYTE_W = coag_pkg::BYTE_W
) (
    input  wire logic                 clk,          // CPU clock, 10 MHz
    input  wire logic                 rstn,         // Async reset, active low
    input  wire logic                 start,        // Begin decoding one instruction
    input  wire coag_pkg::coag_mode_t mode,         // Addressing mode of the opcode
    input  wire coag_pkg::coag_inh_t  inhOp,        // Inherent control operation
    input  wire logic                 useY,         // Select Y instead of X
    input  wire logic                 isRmw,        // Read-modify-write instruction
    input  wire logic [15:0]          opcodeAddr,   // Address of the opcode byte
    input  wire logic [7:0]           indexX,       // Index register X
    input  wire logic [7:0]           indexY,       // Index register Y
    input  wire logic                 irqPending,   // Interrupt request, ends wait
    input  wire logic                 extWake,      // External wake, ends halt
    input  wire logic                 memAck,       // Read data valid on memRdata
    input  wire logic [7:0]           memRdata,     // Memory read data
    output logic                      memRd,        // Read request, held until memAck
    output logic [15:0]               memAddr,      // Read address
    output logic                      busy,         // Decode in progress
    output logic                      done,         // Result valid, one cycle
    output logic                      illegal,      // Rejected mode, with done
    output logic [15:0]               effAddr,      // Effective operand address
    output logic [7:0]                operand,      // Immediate operand value
    output logic [15:0]               branchTarget, // Relative branch target
    output logic [1:0]                opndCount,    // Bytes fetched after opcode
    output logic [1:0]                irqMask,      // Interrupt mask level
    output logic                      waitIdle,     // Core idle until interrupt
    output logic                      oscStop       // Oscillator stopped
);

    if (ADDR_W != 16 || BYTE_W != 8) begin : g_width_check
        $error("coag_addr_gen serves only 16-bit addresses and 8-bit bytes");
    end

    // The decoder tables assume the full mode set, nothing more or less
    if (coag_pkg::MODE_COUNT != int'(coag_pkg::M_BTR_I) + 1) begin : g_mode_check
        $error("coag_addr_gen expects seventeen addressing modes");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_OPND, ST_PTR, ST_CALC} coag_state_t;

    coag_state_t          state_reg;
    coag_pkg::coag_mode_t mode_reg;
    coag_pkg::coag_inh_t  inh_reg;
    logic [15:0]          pc_reg;
    logic [7:0]           idx_reg;
    logic [7:0]           byteBuf_reg [0:1];
    logic [15:0]          ptrVal_reg;
    logic [7:0]           ptrAddr_reg;
    logic [1:0]           fetchCnt_reg;
    logic [1:0]           ptrCnt_reg;
    logic                 memRd_reg;
    logic [15:0]          memAddr_reg;
    logic                 busy_reg;
    logic                 done_reg;
    logic                 illegal_reg;
    logic [15:0]          effAddr_reg;
    logic [7:0]           operand_reg;
    logic [15:0]          branch_reg;
    logic [1:0]           irqMask_reg;
    logic                 waitIdle_reg;
    logic                 oscStop_reg;

    logic [1:0] inOpnd, inPtr, curOpnd, curPtr;
    logic       inLong, curRel, curRelPtr;
    logic       accept, rejectNow;
    logic [15:0] effAddr_next, branch_next, instrEnd;
    logic [7:0]  relOff;

    coag_mode_decode u_in_dec (
        .mode      (mode),
        .opndBytes (inOpnd),
        .ptrBytes  (inPtr),
        .isLong    (inLong),
        .usesIndex (),
        .isRel     (),
        .relViaPtr ()
    );

    coag_mode_decode u_cur_dec (
        .mode      (mode_reg),
        .opndBytes (curOpnd),
        .ptrBytes  (curPtr),
        .isLong    (),
        .usesIndex (),
        .isRel     (curRel),
        .relViaPtr (curRelPtr)
    );

    // No new instruction is taken while the core sleeps
    assign accept    = (state_reg == ST_IDLE) && start && !waitIdle_reg && !oscStop_reg;
    assign rejectNow = isRmw && inLong;

    // Sequencer: operand bytes from the instruction stream, then pointer bytes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg      <= ST_IDLE;
            mode_reg       <= coag_pkg::M_INH;
            inh_reg        <= coag_pkg::INH_OTHER;
            pc_reg         <= coag_pkg::ADDR_RESET;
            idx_reg        <= coag_pkg::BYTE_RESET;
            byteBuf_reg[0] <= coag_pkg::BYTE_RESET;
            byteBuf_reg[1] <= coag_pkg::BYTE_RESET;
            ptrVal_reg     <= coag_pkg::ADDR_RESET;
            ptrAddr_reg    <= coag_pkg::BYTE_RESET;
            fetchCnt_reg   <= 2'h0;
            ptrCnt_reg     <= 2'h0;
            memRd_reg      <= 1'b0;
            memAddr_reg    <= coag_pkg::ADDR_RESET;
            busy_reg       <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept && !rejectNow) begin
                        mode_reg     <= mode;
                        inh_reg      <= inhOp;
                        pc_reg       <= opcodeAddr;
                        // Index value is copied, never written back
                        idx_reg      <= useY ? indexY : indexX;
                        fetchCnt_reg <= 2'h0;
                        ptrCnt_reg   <= 2'h0;
                        ptrVal_reg   <= coag_pkg::ADDR_RESET;
                        busy_reg     <= 1'b1;
                        if (inOpnd == 2'h0) begin
                            state_reg <= ST_CALC;
                        end else begin
                            state_reg   <= ST_OPND;
                            memRd_reg   <= 1'b1;
                            memAddr_reg <= opcodeAddr + 16'h0001;
                        end
                    end
                end
                ST_OPND: begin
                    if (memAck) begin
                        byteBuf_reg[fetchCnt_reg[0]] <= memRdata;
                        fetchCnt_reg <= fetchCnt_reg + 2'h1;
                        if (fetchCnt_reg + 2'h1 == curOpnd) begin
                            if (curPtr != 2'h0) begin
                                // Pointer sits in page zero
                                state_reg   <= ST_PTR;
                                ptrAddr_reg <= (fetchCnt_reg == 2'h0) ? memRdata
                                                                      : byteBuf_reg[0];
                                memAddr_reg <= {coag_pkg::PAGE_ZERO_HI,
                                                (fetchCnt_reg == 2'h0) ? memRdata
                                                                       : byteBuf_reg[0]};
                            end else begin
                                state_reg <= ST_CALC;
                                memRd_reg <= 1'b0;
                            end
                        end else begin
                            memAddr_reg <= memAddr_reg + 16'h0001;
                        end
                    end
                end
                ST_PTR: begin
                    if (memAck) begin
                        // First byte read shifts into the high half when a second byte follows
                        ptrVal_reg <= {ptrVal_reg[7:0], memRdata};
                        ptrCnt_reg <= ptrCnt_reg + 2'h1;
                        if (ptrCnt_reg + 2'h1 == curPtr) begin
                            state_reg <= ST_CALC;
                            memRd_reg <= 1'b0;
                        end else begin
                            // Word pointer wraps inside page zero
                            ptrAddr_reg <= ptrAddr_reg + 8'h01;
                            memAddr_reg <= {coag_pkg::PAGE_ZERO_HI, ptrAddr_reg + 8'h01};
                        end
                    end
                end
                ST_CALC: begin
                    state_reg <= ST_IDLE;
                    busy_reg  <= 1'b0;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    memRd_reg <= 1'b0;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    assign instrEnd = pc_reg + 16'h0001 + {14'h0000, curOpnd};
    assign relOff   = curRelPtr ? ptrVal_reg[7:0]
                    : (curOpnd == 2'h2) ? byteBuf_reg[1] : byteBuf_reg[0];
    assign branch_next = curRel ? instrEnd + {{8{relOff[7]}}, relOff}
                                : instrEnd;

    always_comb begin
        effAddr_next = coag_pkg::ADDR_RESET;
        case (mode_reg)
            coag_pkg::M_DIR_S, coag_pkg::M_BIT_D, coag_pkg::M_BTR_D:
                effAddr_next = {coag_pkg::PAGE_ZERO_HI, byteBuf_reg[0]};
            coag_pkg::M_DIR_L:
                effAddr_next = {byteBuf_reg[0], byteBuf_reg[1]};
            coag_pkg::M_IDX_0:
                effAddr_next = {coag_pkg::PAGE_ZERO_HI, idx_reg};
            coag_pkg::M_IDX_S:
                effAddr_next = {8'h00, idx_reg} + {8'h00, byteBuf_reg[0]};
            coag_pkg::M_IDX_L:
                effAddr_next = {byteBuf_reg[0], byteBuf_reg[1]} + {8'h00, idx_reg};
            coag_pkg::M_IND_S, coag_pkg::M_BIT_I, coag_pkg::M_BTR_I:
                effAddr_next = {coag_pkg::PAGE_ZERO_HI, ptrVal_reg[7:0]};
            coag_pkg::M_IND_L:
                effAddr_next = ptrVal_reg;
            coag_pkg::M_IIX_S:
                effAddr_next = {8'h00, ptrVal_reg[7:0]} + {8'h00, idx_reg};
            coag_pkg::M_IIX_L:
                effAddr_next = ptrVal_reg + {8'h00, idx_reg};
            default:
                effAddr_next = coag_pkg::ADDR_RESET;
        endcase
    end

    // Results are registered one cycle before any operand access may start
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_reg    <= 1'b0;
            illegal_reg <= 1'b0;
            effAddr_reg <= coag_pkg::ADDR_RESET;
            operand_reg <= coag_pkg::BYTE_RESET;
            branch_reg  <= coag_pkg::ADDR_RESET;
        end else begin
            done_reg    <= 1'b0;
            illegal_reg <= 1'b0;
            if (accept && rejectNow) begin
                done_reg    <= 1'b1;
                illegal_reg <= 1'b1;
            end else if (state_reg == ST_CALC) begin
                done_reg    <= 1'b1;
                effAddr_reg <= effAddr_next;
                operand_reg <= (mode_reg == coag_pkg::M_IMM) ? byteBuf_reg[0]
                                                            : coag_pkg::BYTE_RESET;
                branch_reg  <= branch_next;
            end
        end
    end

    // Interrupt mask and low-power state from inherent operations
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqMask_reg <= coag_pkg::MASK_RESET;
        end else if (state_reg == ST_CALC && mode_reg == coag_pkg::M_INH) begin
            if (inh_reg == coag_pkg::INH_SET_MASK) begin
                irqMask_reg <= coag_pkg::MASK_LEVEL_SET;
            end else if (inh_reg == coag_pkg::INH_CLR_MASK) begin
                irqMask_reg <= coag_pkg::MASK_LEVEL_CLR;
            end
        end
    end

    // Entry wins over a wake arriving in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            waitIdle_reg <= 1'b0;
            oscStop_reg  <= 1'b0;
        end else begin
            if (state_reg == ST_CALC && mode_reg == coag_pkg::M_INH
                    && inh_reg == coag_pkg::INH_WAIT) begin
                waitIdle_reg <= 1'b1;
            end else if (irqPending) begin
                waitIdle_reg <= 1'b0;
            end
            if (state_reg == ST_CALC && mode_reg == coag_pkg::M_INH
                    && inh_reg == coag_pkg::INH_HALT) begin
                oscStop_reg <= 1'b1;
            end else if (extWake) begin
                oscStop_reg <= 1'b0;
            end
        end
    end

    assign memRd        = memRd_reg;
    assign memAddr      = memAddr_reg;
    assign busy         = busy_reg;
    assign done         = done_reg;
    assign illegal      = illegal_reg;
    assign effAddr      = effAddr_reg;
    assign operand      = operand_reg;
    assign branchTarget = branch_reg;
    assign opndCount    = fetchCnt_reg;
    assign irqMask      = irqMask_reg;
    assign waitIdle     = waitIdle_reg;
    assign oscStop      = oscStop_reg;

    a_inh_no_fetch: assert property (@(posedge clk) disable iff (!rstn)
        accept && mode == coag_pkg::M_INH |=> !memRd_reg ##1 done_reg)
        else $error("inherent instruction fetched a byte");

    a_imm_operand: assert property (@(posedge clk) disable iff (!rstn)
        done_reg && !illegal_reg && mode_reg == coag_pkg::M_IMM
            |-> fetchCnt_reg == 2'h1 && operand_reg == byteBuf_reg[0])
        else $error("immediate operand wrong");

    a_short_page_zero: assert property (@(posedge clk) disable iff (!rstn)
        done_reg && !illegal_reg && (mode_reg == coag_pkg::M_DIR_S
            || mode_reg == coag_pkg::M_IND_S || mode_reg == coag_pkg::M_IDX_0)
            |-> effAddr_reg[15:8] == 8'h00)
        else $error("short address left page zero");

    a_long_word_order: assert property (@(posedge clk) disable iff (!rstn)
        done_reg && !illegal_reg && mode_reg == coag_pkg::M_DIR_L
            |-> fetchCnt_reg == 2'h2 && effAddr_reg == {byteBuf_reg[0], byteBuf_reg[1]})
        else $error("long direct address wrong");

    a_idx_short_sum: assert property (@(posedge clk) disable iff (!rstn)
        done_reg && !illegal_reg && mode_reg == coag_pkg::M_IDX_S
            |-> effAddr_reg == {8'h00, idx_reg} + {8'h00, byteBuf_reg[0]}
                && effAddr_reg <= coag_pkg::SHORT_IDX_MAX)
        else $error("short indexed sum wrong");

    a_ptr_page_zero: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == ST_PTR && memRd_reg |-> memAddr_reg[15:8] == 8'h00)
        else $error("pointer read outside page zero");

    a_rmw_long_reject: assert property (@(posedge clk) disable iff (!rstn)
        accept && isRmw && (mode == coag_pkg::M_DIR_L || mode == coag_pkg::M_IDX_L)
            |=> done_reg && illegal_reg && state_reg == ST_IDLE)
        else $error("long read-modify-write accepted");

    a_mask_set_level: assert property (@(posedge clk) disable iff (!rstn)
        accept && mode == coag_pkg::M_INH && inhOp == coag_pkg::INH_SET_MASK
            |-> ##2 irqMask_reg == 2'h3)
        else $error("mask not raised to level 3");

    a_mask_clr_level: assert property (@(posedge clk) disable iff (!rstn)
        accept && mode == coag_pkg::M_INH && inhOp == coag_pkg::INH_CLR_MASK
            |-> ##2 irqMask_reg == 2'h0)
        else $error("mask not lowered to level 0");

    a_halt_stops_osc: assert property (@(posedge clk) disable iff (!rstn)
        accept && mode == coag_pkg::M_INH && inhOp == coag_pkg::INH_HALT && !extWake
            |-> ##2 oscStop_reg && !busy_reg)
        else $error("halt did not stop oscillator");

endmodule

// *** design/coag_mode_decode.sv ***
`timescale 1ns/1ps
module coag_mode_decode (
    input  wire coag_pkg::coag_mode_t mode,       // Addressing mode of the opcode
    output logic [1:0]                opndBytes,  // Bytes that follow the opcode
    output logic [1:0]                ptrBytes,   // Pointer bytes read from page zero
    output logic                      isLong,     // Long form of the mode
    output logic                      usesIndex,  // Index register joins the sum
    output logic                      isRel,      // Branch target is formed
    output logic                      relViaPtr   // Branch offset read through pointer
);

    always_comb begin
        opndBytes = 2'h0;
        ptrBytes  = 2'h0;
        isLong    = 1'b0;
        usesIndex = 1'b0;
        isRel     = 1'b0;
        relViaPtr = 1'b0;
        case (mode)
            coag_pkg::M_INH: begin
                opndBytes = 2'h0;
            end
            coag_pkg::M_IMM, coag_pkg::M_DIR_S, coag_pkg::M_BIT_D: begin
                opndBytes = 2'h1;
            end
            coag_pkg::M_DIR_L: begin
                opndBytes = 2'h2;
                isLong    = 1'b1;
            end
            coag_pkg::M_IDX_0: begin
                usesIndex = 1'b1;
            end
            coag_pkg::M_IDX_S: begin
                opndBytes = 2'h1;
                usesIndex = 1'b1;
            end
            coag_pkg::M_IDX_L: begin
                opndBytes = 2'h2;
                usesIndex = 1'b1;
                isLong    = 1'b1;
            end
            coag_pkg::M_IND_S, coag_pkg::M_BIT_I: begin
                opndBytes = 2'h1;
                ptrBytes  = 2'h1;
            end
            coag_pkg::M_IND_L: begin
                opndBytes = 2'h1;
                ptrBytes  = 2'h2;
                isLong    = 1'b1;
            end
            coag_pkg::M_IIX_S: begin
                opndBytes = 2'h1;
                ptrBytes  = 2'h1;
                usesIndex = 1'b1;
            end
            coag_pkg::M_IIX_L: begin
                opndBytes = 2'h1;
                ptrBytes  = 2'h2;
                usesIndex = 1'b1;
                isLong    = 1'b1;
            end
            coag_pkg::M_REL_D: begin
                opndBytes = 2'h1;
                isRel     = 1'b1;
            end
            coag_pkg::M_REL_I: begin
                opndBytes = 2'h1;
                ptrBytes  = 2'h1;
                isRel     = 1'b1;
                relViaPtr = 1'b1;
            end
            coag_pkg::M_BTR_D: begin
                opndBytes = 2'h2;
                isRel     = 1'b1;
            end
            coag_pkg::M_BTR_I: begin
                opndBytes = 2'h2;
                ptrBytes  = 2'h1;
                isRel     = 1'b1;
            end
            default: begin
                opndBytes = 2'h0;
            end
        endcase
    end

endmodule

// *** design/coag_pkg.sv ***
package coag_pkg;

    // Seventeen addressing modes in seven groups
    typedef enum logic [4:0] {
        M_INH,
        M_IMM,
        M_DIR_S,
        M_DIR_L,
        M_IDX_0,
        M_IDX_S,
        M_IDX_L,
        M_IND_S,
        M_IND_L,
        M_IIX_S,
        M_IIX_L,
        M_REL_D,
        M_REL_I,
        M_BIT_D,
        M_BIT_I,
        M_BTR_D,
        M_BTR_I
    } coag_mode_t;

    typedef enum logic [2:0] {
        INH_OTHER,
        INH_SET_MASK,
        INH_CLR_MASK,
        INH_WAIT,
        INH_HALT
    } coag_inh_t;

    localparam int          ADDR_W         = 16;
    localparam int          BYTE_W         = 8;
    localparam int          MODE_COUNT     = 17;
    localparam logic [1:0]  MASK_LEVEL_SET = 2'h3;
    localparam logic [1:0]  MASK_LEVEL_CLR = 2'h0;
    localparam logic [1:0]  MASK_RESET     = 2'h3;
    localparam logic [7:0]  PAGE_ZERO_HI   = 8'h00;
    localparam logic [15:0] SHORT_IDX_MAX  = 16'h01fe;
    localparam logic [15:0] ADDR_RESET     = 16'h0000;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;

endpackage

// *** testbench/coag_mem_model.sv ***
`timescale 1ns/1ps
module coag_mem_model (
    input  wire logic        clk,      // CPU clock
    input  wire logic        rstn,     // Async reset, active low
    input  wire logic        slow,     // Answer only every other cycle
    input  wire logic        memRd,    // Read request
    input  wire logic [15:0] memAddr,  // Read address
    output logic             memAck,   // Data valid
    output logic [7:0]       memRdata  // Read data
);
    logic [7:0] ram [0:65535];
    logic [7:0] lastReg;
    logic       phaseReg;
    assign memAck = memRd && (!slow || phaseReg);
    // Idle bus shows the inverse of the last byte so stale data never matches
    assign memRdata = memAck ? ram[memAddr] : ~lastReg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phaseReg <= 1'b0;
            lastReg  <= 8'h00;
        end else begin
            phaseReg <= ~phaseReg;
            if (memAck) begin
                lastReg <= memRdata;
            end
        end
    end
endmodule

// *** testbench/test_cpu_operand_address_generation.sv ***
`timescale 1ns/1ps
module test_cpu_operand_address_generation;
    logic                 clk, rstn, start, useY, isRmw, irqPending, extWake, slow;
    logic                 memRd, memAck, busy, done, illegal, waitIdle, oscStop;
    coag_pkg::coag_mode_t mode;
    coag_pkg::coag_inh_t  inhOp;
    logic [15:0]          opcodeAddr, memAddr, effAddr, branchTarget;
    logic [7:0]           indexX, indexY, memRdata, operand;
    logic [1:0]           opndCount, irqMask;
    int                   failures, numChecks;
    coag_addr_gen dut (.clk(clk), .rstn(rstn), .start(start), .mode(mode), .inhOp(inhOp),
        .useY(useY), .isRmw(isRmw), .opcodeAddr(opcodeAddr), .indexX(indexX),
        .indexY(indexY), .irqPending(irqPending), .extWake(extWake), .memAck(memAck),
        .memRdata(memRdata), .memRd(memRd), .memAddr(memAddr), .busy(busy), .done(done),
        .illegal(illegal), .effAddr(effAddr), .operand(operand),
        .branchTarget(branchTarget), .opndCount(opndCount), .irqMask(irqMask),
        .waitIdle(waitIdle), .oscStop(oscStop));
    coag_mem_model mem (.clk(clk), .rstn(rstn), .slow(slow), .memRd(memRd),
        .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (failures == 0 && numChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic run(input coag_pkg::coag_mode_t m, input coag_pkg::coag_inh_t op,
                       input logic y, input logic rmw);
        int n;
        mode = m;
        inhOp = op;
        useY = y;
        isRmw = rmw;
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        if (!rmw) chk("busy", {15'h0, busy}, 16'h1);
        n = 0;
        while (done !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 30) failures++;
    endtask
    task automatic addr(input coag_pkg::coag_mode_t m, input logic y, input logic [15:0] eff,
                        input logic [1:0] cnt);
        run(m, coag_pkg::INH_OTHER, y, 1'b0);
        chk("effAddr", effAddr, eff);
        chk("opndCount", {14'h0, opndCount}, {14'h0, cnt});
        chk("memRd", {15'h0, memRd}, 16'h0);
    endtask
    task automatic sleep(input coag_pkg::coag_inh_t op);
        run(coag_pkg::M_INH, op, 1'b0, 1'b0);
        repeat (2) @(posedge clk);
        #1 chk("sleep", {14'h0, oscStop, waitIdle}, (op == coag_pkg::INH_HALT) ? 16'h2 : 16'h1);
        irqPending = (op == coag_pkg::INH_WAIT);
        extWake = (op == coag_pkg::INH_HALT);
        repeat (2) @(posedge clk);
        #1 chk("wake", {14'h0, oscStop, waitIdle}, 16'h0);
        irqPending = 1'b0;
        extWake = 1'b0;
    endtask
    initial begin
        #300000 failures++;
        conclude();
    end
    initial begin
        {rstn, start, useY, isRmw, irqPending, extWake, slow} = '0;
        mode = coag_pkg::M_INH;
        inhOp = coag_pkg::INH_OTHER;
        opcodeAddr = 16'h1230;
        indexX = 8'hff;
        indexY = 8'h02;
        mem.ram[16'h1231] = 8'hff;
        mem.ram[16'h1232] = 8'h34;
        mem.ram[16'h00ff] = 8'hc1;
        mem.ram[16'h0000] = 8'h07;
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        chk("irqMask", {14'h0, irqMask}, {14'h0, coag_pkg::MASK_RESET});
        addr(coag_pkg::M_DIR_S, 1'b0, 16'h00ff, 2'h1);
        addr(coag_pkg::M_DIR_L, 1'b0, 16'hff34, 2'h2);
        addr(coag_pkg::M_IDX_0, 1'b0, 16'h00ff, 2'h0);
        addr(coag_pkg::M_IDX_S, 1'b0, 16'h01fe, 2'h1);
        slow = 1'b1;
        addr(coag_pkg::M_IDX_L, 1'b1, 16'hff36, 2'h2);
        addr(coag_pkg::M_IND_S, 1'b0, 16'h00c1, 2'h1);
        addr(coag_pkg::M_IND_L, 1'b0, 16'hc107, 2'h1);
        chk("memAddr", memAddr, 16'h0000);
        addr(coag_pkg::M_IIX_S, 1'b1, 16'h00c3, 2'h1);
        addr(coag_pkg::M_IIX_S, 1'b0, 16'h01c0, 2'h1);
        addr(coag_pkg::M_IIX_L, 1'b0, 16'hc206, 2'h1);
        addr(coag_pkg::M_IMM, 1'b0, 16'h0000, 2'h1);
        chk("operand", {8'h0, operand}, 16'h00ff);
        addr(coag_pkg::M_REL_D, 1'b0, 16'h0000, 2'h1);
        chk("branchTarget", branchTarget, 16'h1231);
        addr(coag_pkg::M_REL_I, 1'b0, 16'h0000, 2'h1);
        chk("branchTarget", branchTarget, 16'h11f3);
        addr(coag_pkg::M_BIT_D, 1'b0, 16'h00ff, 2'h1);
        addr(coag_pkg::M_BIT_I, 1'b0, 16'h00c1, 2'h1);
        addr(coag_pkg::M_BTR_D, 1'b0, 16'h00ff, 2'h2);
        chk("branchTarget", branchTarget, 16'h1267);
        addr(coag_pkg::M_BTR_I, 1'b0, 16'h00c1, 2'h2);
        chk("branchTarget", branchTarget, 16'h1267);
        run(coag_pkg::M_DIR_L, coag_pkg::INH_OTHER, 1'b0, 1'b1);
        chk("illegal", {15'h0, illegal}, 16'h1);
        @(posedge clk);
        #1;
        run(coag_pkg::M_INH, coag_pkg::INH_CLR_MASK, 1'b0, 1'b0);
        chk("irqMask", {14'h0, irqMask}, 16'h0);
        chk("opndCount", {14'h0, opndCount}, 16'h0);
        run(coag_pkg::M_INH, coag_pkg::INH_SET_MASK, 1'b0, 1'b0);
        chk("irqMask", {14'h0, irqMask}, 16'h3);
        sleep(coag_pkg::INH_WAIT);
        sleep(coag_pkg::INH_HALT);
        conclude();
    end
endmodule
